// ===== ibh_consts.svh
/*
 * Constants of the two-wire bus baud, hold and own-address block.
 * Assumes a 20 MHz bus clock and inclusion by ibh_pkg and the block itself.
 */
`ifndef IBH_CONSTS_SVH
`define IBH_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register select codes on the register port
`define IBH_SEL_OWN_ADDR 1'h0
`define IBH_SEL_DIVIDER 1'h1

// reset values
`define IBH_OWN_ADDR_RST 8'h00
`define IBH_DIVIDER_RST 8'h00

// field layout of clock_divider_select
`define IBH_RATE_MULTIPLIER_SEL_HI 7
`define IBH_RATE_MULTIPLIER_SEL_LO 6
`define IBH_ICR_HI 5
`define IBH_ICR_LO 0

// field layout of own_slave_address; bit 0 is reserved and reads zero
`define IBH_ADDR_HI 7
`define IBH_ADDR_LO 1
`define IBH_ADDR_RSVD 1'h0
`define IBH_OWN_FIELD_RST 7'h00

// multiplier codes and the factor minus one that the prescaler counts to
`define IBH_MUL_X1 2'h0
`define IBH_MUL_X2 2'h1
`define IBH_MUL_X4 2'h2
`define IBH_PRE_X1 2'h0
`define IBH_PRE_X2 2'h1
`define IBH_PRE_X4 2'h3

// counter widths and small constants
`define IBH_CNT_W 12
`define IBH_CNT_ONE 12'h001
`define IBH_CNT_ZERO 12'h000
`define IBH_PRE_ONE 2'h1

// lookup entry slices: divider, data hold, start hold, stop hold
`define IBH_LUT_DIV 43:32
`define IBH_LUT_SDA 31:22
`define IBH_LUT_STA 21:11
`define IBH_LUT_STO 10:0

`endif

// ===== ibh_pkg.sv
/*
 * Types of the two-wire bus baud, hold and own-address block.
 * Assumes ibh_consts.svh is on the include path.
 */
package ibh_pkg;
`include "ibh_consts.svh"

   typedef enum logic [2:0] {
      IBH_IDLE      = 3'b000,
      IBH_START     = 3'b001,
      IBH_LOW_HOLD  = 3'b010,
      IBH_LOW_REST  = 3'b011,
      IBH_HIGH      = 3'b100,
      IBH_STOP_HOLD = 3'b101
   } ibh_state_type;

endpackage

// ===== ibh_baud_hold.sv
/*
 * Own-address compare, rate lookup and master clock/start/stop timing.
 * Assumes open-drain pads (oe high pulls low) and an outer byte shifter.
 */
`timescale 1ns/100ps
`include "ibh_consts.svh"

module ibh_baud_hold import ibh_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic regWrEn,
   input wire logic regSel,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic moduleEnable,
   input wire logic masterMode,
   input wire logic txBit,
   input wire logic [7:0] rxAddrByte,
   input wire logic rxAddrValid,
   output logic addrMatch,
   output logic bitDone,
   output logic rxBit,
   output logic busIdle,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);

   ////////////////////////////////////////////////////////////////////////////
   // divider and hold lookup, one entry per rate code
   function automatic logic [43:0] rateEntry(input logic [5:0] code);
      logic [43:0] t;
      case (code)
         6'h01: t = {12'h016, 10'h007, 11'h007, 11'h00C};
         6'h02: t = {12'h018, 10'h008, 11'h008, 11'h00D};
         6'h03: t = {12'h01A, 10'h008, 11'h009, 11'h00E};
         6'h04: t = {12'h01C, 10'h009, 11'h00A, 11'h00F};
         6'h05: t = {12'h01E, 10'h009, 11'h00B, 11'h010};
         6'h06: t = {12'h022, 10'h00A, 11'h00D, 11'h012};
         6'h07: t = {12'h028, 10'h00A, 11'h010, 11'h015};
         6'h08: t = {12'h01C, 10'h007, 11'h00A, 11'h00F};
         6'h09: t = {12'h020, 10'h007, 11'h00C, 11'h011};
         6'h0A: t = {12'h024, 10'h009, 11'h00E, 11'h013};
         6'h0B: t = {12'h028, 10'h009, 11'h010, 11'h015};
         6'h0C: t = {12'h02C, 10'h00B, 11'h012, 11'h017};
         6'h0D: t = {12'h030, 10'h00B, 11'h014, 11'h019};
         6'h0E: t = {12'h038, 10'h00D, 11'h018, 11'h01D};
         6'h0F: t = {12'h044, 10'h00D, 11'h01E, 11'h023};
         6'h10: t = {12'h030, 10'h009, 11'h012, 11'h019};
         6'h11: t = {12'h038, 10'h009, 11'h016, 11'h01D};
         6'h12: t = {12'h040, 10'h00D, 11'h01A, 11'h021};
         6'h13: t = {12'h048, 10'h00D, 11'h01E, 11'h025};
         6'h14: t = {12'h050, 10'h011, 11'h022, 11'h029};
         6'h15: t = {12'h058, 10'h011, 11'h026, 11'h02D};
         6'h16: t = {12'h068, 10'h015, 11'h02E, 11'h035};
         6'h17: t = {12'h080, 10'h015, 11'h03A, 11'h041};
         6'h18: t = {12'h050, 10'h009, 11'h026, 11'h029};
         6'h19: t = {12'h060, 10'h009, 11'h02E, 11'h031};
         6'h1A: t = {12'h070, 10'h011, 11'h036, 11'h039};
         6'h1B: t = {12'h080, 10'h011, 11'h03E, 11'h041};
         6'h1C: t = {12'h090, 10'h019, 11'h046, 11'h049};
         6'h1D: t = {12'h0A0, 10'h019, 11'h04E, 11'h051};
         6'h1E: t = {12'h0C0, 10'h021, 11'h05E, 11'h061};
         6'h1F: t = {12'h0F0, 10'h021, 11'h076, 11'h079};
         6'h20: t = {12'h0A0, 10'h011, 11'h04E, 11'h051};
         6'h21: t = {12'h0C0, 10'h011, 11'h05E, 11'h061};
         6'h22: t = {12'h0E0, 10'h021, 11'h06E, 11'h071};
         6'h23: t = {12'h100, 10'h021, 11'h07E, 11'h081};
         6'h24: t = {12'h120, 10'h031, 11'h08E, 11'h091};
         6'h25: t = {12'h140, 10'h031, 11'h09E, 11'h0A1};
         6'h26: t = {12'h180, 10'h041, 11'h0BE, 11'h0C1};
         6'h27: t = {12'h1E0, 10'h041, 11'h0EE, 11'h0F1};
         6'h28: t = {12'h140, 10'h021, 11'h09E, 11'h0A1};
         6'h29: t = {12'h180, 10'h021, 11'h0BE, 11'h0C1};
         6'h2A: t = {12'h1C0, 10'h041, 11'h0DE, 11'h0E1};
         6'h2B: t = {12'h200, 10'h041, 11'h0FE, 11'h101};
         6'h2C: t = {12'h240, 10'h061, 11'h11E, 11'h121};
         6'h2D: t = {12'h280, 10'h061, 11'h13E, 11'h141};
         6'h2E: t = {12'h300, 10'h081, 11'h17E, 11'h181};
         6'h2F: t = {12'h3C0, 10'h081, 11'h1DE, 11'h1E1};
         6'h30: t = {12'h280, 10'h041, 11'h13E, 11'h141};
         6'h31: t = {12'h300, 10'h041, 11'h17E, 11'h181};
         6'h32: t = {12'h380, 10'h081, 11'h1BE, 11'h1C1};
         6'h33: t = {12'h400, 10'h081, 11'h1FE, 11'h201};
         6'h34: t = {12'h480, 10'h0C1, 11'h23E, 11'h241};
         6'h35: t = {12'h500, 10'h0C1, 11'h27E, 11'h281};
         6'h36: t = {12'h600, 10'h101, 11'h2FE, 11'h301};
         6'h37: t = {12'h780, 10'h101, 11'h3BE, 11'h3C1};
         6'h38: t = {12'h500, 10'h081, 11'h27E, 11'h281};
         6'h39: t = {12'h600, 10'h081, 11'h2FE, 11'h301};
         6'h3A: t = {12'h700, 10'h101, 11'h37E, 11'h381};
         6'h3B: t = {12'h800, 10'h101, 11'h3FE, 11'h401};
         6'h3C: t = {12'h900, 10'h181, 11'h47E, 11'h481};
         6'h3D: t = {12'hA00, 10'h181, 11'h4FE, 11'h501};
         6'h3E: t = {12'hC00, 10'h201, 11'h5FE, 11'h601};
         6'h3F: t = {12'hF00, 10'h201, 11'h77E, 11'h781};
         default: t = {12'h014, 10'h007, 11'h006, 11'h00B};
      endcase
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register file
   logic [6:0] ownAddr_ff, nxt_ownAddr;
   logic [7:0] divSel_ff, nxt_divSel, regRdData_ff, nxt_regRdData;
   logic addrMatch_ff, nxt_addrMatch;
   always_comb begin
      nxt_ownAddr = ownAddr_ff;
      nxt_divSel = divSel_ff;
      if (regWrEn && regSel == `IBH_SEL_OWN_ADDR) begin
         nxt_ownAddr = regWrData[`IBH_ADDR_HI:`IBH_ADDR_LO];
      end else if (regWrEn && regSel == `IBH_SEL_DIVIDER) begin
         nxt_divSel = regWrData;
      end
      nxt_regRdData = (regSel == `IBH_SEL_OWN_ADDR) ? {nxt_ownAddr, `IBH_ADDR_RSVD} : nxt_divSel;
      nxt_addrMatch = rxAddrValid ? (rxAddrByte[`IBH_ADDR_HI:`IBH_ADDR_LO] == ownAddr_ff) : addrMatch_ff;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ownAddr_ff <= `IBH_OWN_FIELD_RST;
         divSel_ff <= `IBH_DIVIDER_RST;
         regRdData_ff <= `IBH_OWN_ADDR_RST;
         addrMatch_ff <= 1'b0;
      end else begin
         ownAddr_ff <= nxt_ownAddr;
         divSel_ff <= nxt_divSel;
         regRdData_ff <= nxt_regRdData;
         addrMatch_ff <= nxt_addrMatch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a change counts once stages two and three agree
   logic [2:0] sclSync_ff, sdaSync_ff;
   logic sclLvl_ff, sdaLvl_ff, nxt_sclLvl, nxt_sdaLvl;
   always_comb begin
      nxt_sclLvl = (sclSync_ff[1] == sclSync_ff[2]) ? sclSync_ff[2] : sclLvl_ff;
      nxt_sdaLvl = (sdaSync_ff[1] == sdaSync_ff[2]) ? sdaSync_ff[2] : sdaLvl_ff;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclSync_ff <= 3'h7;
         sdaSync_ff <= 3'h7;
         sclLvl_ff <= 1'b1;
         sdaLvl_ff <= 1'b1;
      end else begin
         sclSync_ff <= {sclSync_ff[1:0], sclIn};
         sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
         sclLvl_ff <= nxt_sclLvl;
         sdaLvl_ff <= nxt_sdaLvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master timing engine
   ibh_state_type state_ff, nxt_state;
   logic [7:0] actSel_ff, nxt_actSel;
   logic [1:0] pre_ff, nxt_pre, preTop;
   logic [`IBH_CNT_W-1:0] cnt_ff, nxt_cnt, halfDiv;
   logic stopPend_ff, nxt_stopPend, sclOe_ff, nxt_sclOe, sdaOe_ff, nxt_sdaOe, zeroOut_ff;
   logic bitDone_ff, nxt_bitDone, rxBit_ff, nxt_rxBit, busIdle_ff, nxt_busIdle, tick;
   logic [43:0] ent;
   always_comb begin
      ent = rateEntry(actSel_ff[`IBH_ICR_HI:`IBH_ICR_LO]);
      halfDiv = ent[`IBH_LUT_DIV] >> 1;
      // reserved multiplier code falls back to factor one
      preTop = (actSel_ff[`IBH_RATE_MULTIPLIER_SEL_HI:`IBH_RATE_MULTIPLIER_SEL_LO] == `IBH_MUL_X2) ? `IBH_PRE_X2 :
         (actSel_ff[`IBH_RATE_MULTIPLIER_SEL_HI:`IBH_RATE_MULTIPLIER_SEL_LO] == `IBH_MUL_X4) ? `IBH_PRE_X4 : `IBH_PRE_X1;
      tick = (pre_ff == preTop);
      nxt_pre = tick ? 2'h0 : pre_ff + `IBH_PRE_ONE;
      nxt_state = state_ff;
      nxt_actSel = actSel_ff;
      nxt_cnt = tick ? cnt_ff + `IBH_CNT_ONE : cnt_ff;
      nxt_stopPend = stopPend_ff;
      nxt_sclOe = sclOe_ff;
      nxt_sdaOe = sdaOe_ff;
      nxt_bitDone = 1'b0;
      nxt_rxBit = rxBit_ff;
      nxt_busIdle = sclLvl_ff && sdaLvl_ff && state_ff == IBH_IDLE;
      case (state_ff)
         IBH_IDLE: begin
            nxt_actSel = divSel_ff;
            nxt_cnt = `IBH_CNT_ZERO;
            nxt_pre = 2'h0;
            if (moduleEnable && masterMode && sclLvl_ff && sdaLvl_ff) begin
               nxt_sdaOe = 1'b1;
               nxt_state = IBH_START;
            end
         end
         IBH_START: begin
            if (tick && nxt_cnt == {1'h0, ent[`IBH_LUT_STA]}) begin
               nxt_sclOe = 1'b1;
               nxt_cnt = `IBH_CNT_ZERO;
               nxt_state = IBH_LOW_HOLD;
            end
         end
         IBH_LOW_HOLD: begin
            if (tick && nxt_cnt == {2'h0, ent[`IBH_LUT_SDA]}) begin
               nxt_stopPend = !masterMode;
               nxt_sdaOe = masterMode ? !txBit : 1'b1;
               nxt_state = IBH_LOW_REST;
            end
         end
         IBH_LOW_REST: begin
            if (tick && nxt_cnt >= halfDiv) begin
               nxt_sclOe = 1'b0;
               nxt_cnt = `IBH_CNT_ZERO;
               nxt_state = IBH_HIGH;
            end
         end
         IBH_HIGH: begin
            // another party stretching the clock holds the high count at zero
            if (!sclLvl_ff || stopPend_ff) begin
               nxt_cnt = `IBH_CNT_ZERO;
               nxt_pre = 2'h0;
               nxt_state = sclLvl_ff ? IBH_STOP_HOLD : IBH_HIGH;
            end else if (tick && nxt_cnt == halfDiv) begin
               nxt_sclOe = 1'b1;
               nxt_rxBit = sdaLvl_ff;
               nxt_bitDone = 1'b1;
               nxt_actSel = divSel_ff;
               nxt_cnt = `IBH_CNT_ZERO;
               nxt_state = IBH_LOW_HOLD;
            end
         end
         IBH_STOP_HOLD: begin
            if (tick && nxt_cnt == {1'h0, ent[`IBH_LUT_STO]}) begin
               nxt_sdaOe = 1'b0;
               nxt_state = IBH_IDLE;
            end
         end
         default: nxt_state = IBH_IDLE;
      endcase
      if (!moduleEnable) begin
         nxt_state = IBH_IDLE;
         nxt_sclOe = 1'b0;
         nxt_sdaOe = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= IBH_IDLE;
         actSel_ff <= `IBH_DIVIDER_RST;
         pre_ff <= 2'h0;
         cnt_ff <= `IBH_CNT_ZERO;
         stopPend_ff <= 1'b0;
         sclOe_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
         bitDone_ff <= 1'b0;
         rxBit_ff <= 1'b1;
         busIdle_ff <= 1'b1;
         zeroOut_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         actSel_ff <= nxt_actSel;
         pre_ff <= nxt_pre;
         cnt_ff <= nxt_cnt;
         stopPend_ff <= nxt_stopPend;
         sclOe_ff <= nxt_sclOe;
         sdaOe_ff <= nxt_sdaOe;
         bitDone_ff <= nxt_bitDone;
         rxBit_ff <= nxt_rxBit;
         busIdle_ff <= nxt_busIdle;
         zeroOut_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; open-drain lines only ever drive low
   assign regRdData = regRdData_ff;
   assign addrMatch = addrMatch_ff;
   assign bitDone = bitDone_ff;
   assign rxBit = rxBit_ff;
   assign busIdle = busIdle_ff;
   assign sclOe = sclOe_ff;
   assign sdaOe = sdaOe_ff;
   assign sclOut = zeroOut_ff;
   assign sdaOut = zeroOut_ff;

endmodule

// ===== ibh_props.sv
/*
 Checker of ibh_baud_hold, watching only its ports.
 Assumes one clock domain and open-drain pads (oe high pulls low).
*/
`timescale 1ns/100ps
module ibh_props
   import ibh_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic regWrEn,
   input wire logic regSel,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic moduleEnable,
   input wire logic [7:0] rxAddrByte,
   input wire logic rxAddrValid,
   input wire logic addrMatch,
   input wire logic bitDone,
   input wire logic busIdle,
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sdaOut,
   input wire logic sdaOe
);
   logic [6:0] ownAddr_ff;

   // shadow of the stored address, compares use it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ownAddr_ff <= 7'h00;
      end else if (regWrEn && !regSel) begin
         ownAddr_ff <= regWrData[7:1];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////////////////
   a_pads_low: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
      else $error("pad output not low");
   a_off_release: assert property (!moduleEnable |=> !sclOe && !sdaOe)
      else $error("lines not released when disabled");
   a_match_follows: assert property (rxAddrValid |=>
      addrMatch == ($past(rxAddrByte[7:1]) == $past(ownAddr_ff)))
      else $error("address compare wrong");
   a_match_hold: assert property (!rxAddrValid |=> $stable(addrMatch))
      else $error("match changed without compare");
   a_rd_addr: assert property (regWrEn && !regSel ##1 !regSel |->
      regRdData == {$past(regWrData[7:1]), 1'b0})
      else $error("address readback wrong");
   a_start_hold: assert property ($rose(sdaOe) && $past(busIdle) |-> !sclOe [*6])
      else $error("start hold too short");
   a_data_hold: assert property ($rose(sclOe) |-> $stable(sdaOe) [*6])
      else $error("data changed too soon");
   a_stop_hold: assert property ($fell(sdaOe) && !sclOe && moduleEnable |->
      $past(sclOe, 10) == 1'b0)
      else $error("stop hold too short");
   a_done_pulse: assert property (bitDone |=> !bitDone)
      else $error("bit done longer than one cycle");

   c_start: cover property ($rose(sdaOe) && $past(busIdle));
   c_bit: cover property (bitDone);
   c_match: cover property ($rose(addrMatch));
endmodule

bind ibh_baud_hold ibh_props u_props (.clk, .rst_b, .regWrEn, .regSel, .regWrData, .regRdData,
   .moduleEnable, .rxAddrByte, .rxAddrValid, .addrMatch, .bitDone, .busIdle, .sclOut, .sclOe,
   .sdaOut, .sdaOe);

// ===== ibh_partner.sv
/*
 Remote bus device: pull-ups, clock stretching and a data pull.
 Assumes the bench commands stretch length and data pull.
*/
`timescale 1ns/100ps
module ibh_partner
   import ibh_pkg::*;
(
   input wire logic clk,
   input wire logic sclOe,
   input wire logic sdaOe,
   input wire logic [7:0] stretchLen,
   input wire logic sdaPull,
   output logic sclLine,
   output logic sdaLine
);
   logic [7:0] holdCnt_ff = 8'h00;
   logic sclOeSeen_ff = 1'b0;
   logic [7:0] nxt_holdCnt;

   // stretch starts when the master lets go of the clock
   always_comb begin
      nxt_holdCnt = holdCnt_ff;
      if (sclOeSeen_ff && !sclOe) begin
         nxt_holdCnt = stretchLen;
      end else if (holdCnt_ff != 8'h00) begin
         nxt_holdCnt = holdCnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      holdCnt_ff <= nxt_holdCnt;
      sclOeSeen_ff <= sclOe;
   end

   // pull-ups: a released line reads high, no glitch before stretch loads
   assign sclLine = !(sclOe || (sclOeSeen_ff && stretchLen != 8'h00) || holdCnt_ff != 8'h00);
   assign sdaLine = !(sdaOe || sdaPull);
endmodule

// ===== i2c_baud_hold_and_address_config_bench.sv
/*
 Self-checking bench of ibh_baud_hold with the partner model.
 Assumes a 20 MHz clk; inputs change 2 ns after the rising edge.
*/
`timescale 1ns/100ps
module i2c_baud_hold_and_address_config_bench
   import ibh_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic regWrEn = 1'b0, regSel = 1'b0, moduleEnable = 1'b0, masterMode = 1'b0;
   logic txBit = 1'b1, rxAddrValid = 1'b0, sdaPull = 1'b0;
   logic [7:0] regWrData = 8'h00, rxAddrByte = 8'h00, stretchLen = 8'h00, regRdData;
   logic addrMatch, bitDone, rxBit, busIdle, sclOut, sclOe, sdaOut, sdaOe, sclLine, sdaLine;
   int errCount = 0, compares = 0;
   wire logic [4:0] mon = {busIdle, bitDone, sclLine, sdaOe, sclOe};
   // mul code, rate code, divider, data hold, start hold, stop hold, stretch, pull
   int cfg[5][8] = '{'{0, 'h00, 20, 7, 6, 11, 0, 0}, '{1, 'h07, 40, 10, 16, 21, 25, 1},
      '{2, 'h0F, 68, 13, 30, 35, 0, 0}, '{0, 'h17, 128, 21, 58, 65, 0, 1},
      '{3, 'h1F, 240, 33, 118, 121, 9, 0}};

   initial begin
      forever #25 clk = ~clk;
   end

   ibh_baud_hold u_dut (.clk(clk), .rst_b(rst_b), .regWrEn(regWrEn), .regSel(regSel),
      .regWrData(regWrData), .regRdData(regRdData), .moduleEnable(moduleEnable),
      .masterMode(masterMode), .txBit(txBit), .rxAddrByte(rxAddrByte), .rxAddrValid(rxAddrValid),
      .addrMatch(addrMatch), .bitDone(bitDone), .rxBit(rxBit), .busIdle(busIdle), .sclIn(sclLine),
      .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));

   ibh_partner u_partner (.clk(clk), .sclOe(sclOe), .sdaOe(sdaOe), .stretchLen(stretchLen),
      .sdaPull(sdaPull), .sclLine(sclLine), .sdaLine(sdaLine));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errCount++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic sel, input logic [7:0] d);
      regSel = sel;
      regWrData = d;
      regWrEn = 1'b1;
      tick(1);
      regWrEn = 1'b0;
   endtask

   // bounded wait on one monitored line, counting edges
   task automatic waitFor(input int i, input logic v, output int n);
      n = 0;
      while (mon[i] !== v && n < 20000) begin
         tick(1);
         n++;
      end
      if (n >= 20000) begin
         errCount++;
      end
   endtask

   // hold counts may run a few cycles over by sync and prescale
   function automatic int near(input int n, input int e);
      return (n >= e && n <= e + 5) ? e : n;
   endfunction

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", compares, errCount);
      if (errCount == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      errCount++;
      wrapUp();
   end

   initial begin
      int n;
      int lo;
      int m;
      logic [7:0] ab[4] = '{8'hA4, 8'hA5, 8'hA6, 8'h00};
      tick(2);
      rst_b = 1'b1;
      chk({regRdData, addrMatch, rxBit, busIdle, sclOe, sdaOe}, {8'h00, 5'b01100});
      tick(3);
      moduleEnable = 1'b1;
      $display("test reset done");
      wr(1'b0, 8'hA5);
      chk(regRdData, 8'hA4);
      for (int i = 0; i < 4; i++) begin
         rxAddrByte = ab[i];
         rxAddrValid = 1'b1;
         tick(1);
         chk(addrMatch, i < 2);
      end
      rxAddrValid = 1'b0;
      rxAddrByte = 8'hA4;
      tick(2);
      chk(addrMatch, 1'b0);
      wr(1'b1, 8'hC7);
      chk(regRdData, 8'hC7);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         m = (cfg[i][0] == 1) ? 2 : (cfg[i][0] == 2) ? 4 : 1;
         wr(1'b1, 8'(cfg[i][0] * 64 + cfg[i][1]));
         stretchLen = 8'(cfg[i][6]);
         masterMode = 1'b1;
         waitFor(1, 1'b1, n);
         waitFor(0, 1'b1, n);
         chk(16'(near(n, m * cfg[i][4])), 16'(m * cfg[i][4]));
         sdaPull = cfg[i][7][0];
         waitFor(1, 1'b0, n);
         chk(16'(near(n, m * cfg[i][3])), 16'(m * cfg[i][3]));
         waitFor(0, 1'b0, lo);
         chk(16'(near(n + lo, m * cfg[i][2] / 2)), 16'(m * cfg[i][2] / 2));
         masterMode = 1'b0;
         waitFor(2, 1'b1, n);
         waitFor(3, 1'b1, n);
         chk(16'(near(n, m * cfg[i][2] / 2 + 2)), 16'(m * cfg[i][2] / 2 + 2));
         tick(1);
         chk(rxBit, !cfg[i][7][0]);
         sdaPull = 1'b0;
         waitFor(1, 1'b1, n);
         waitFor(2, 1'b1, n);
         waitFor(1, 1'b0, n);
         chk(16'(near(n, m * cfg[i][5] + 2)), 16'(m * cfg[i][5] + 2));
         waitFor(4, 1'b1, n);
         chk({sclLine, sdaLine, busIdle}, 3'b111);
         $display("test timing %0d done", i);
      end
      masterMode = 1'b1;
      waitFor(1, 1'b1, n);
      moduleEnable = 1'b0;
      tick(1);
      chk({sclOe, sdaOe}, 2'b00);
      $display("test disable done");
      wrapUp();
   end
endmodule
